// *** logic/peripheral_control_port.v ***
// peripheral control port: gp pins, external bus, square timer and edge interrupts
`timescale 1ns/1ps
`include "periph_ctrl_defs.vh"

module peripheral_control_port #(
  parameter HALF_MS_CYCLES = `TIMER_HALF_MS_NS / `CLK_PERIOD_NS,
  parameter PHASE_CYCLES = `BUS_PHASE_CYCLES
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // mode and test
  input wire extPortModeSel,
  input wire extAddrModeSel,
  input wire testSelectPin,
  output reg testModeActive,
  // simple I/O control, bit set means output
  input wire [10:0] pinDirection,
  input wire [10:0] pinWriteData,
  output reg [10:0] pinReadData,
  // timer control
  input wire [5:0] timerPeriodMs,
  output reg timerSquareOut,
  // external interrupts
  input wire extIrqInZero,
  input wire extIrqInOne,
  input wire [1:0] irqMask,
  input wire [1:0] irqClear,
  output reg [1:0] irqPending,
  output reg irqReqOut,
  output reg irqReqOe_n,
  // external bus cycle requests
  input wire busReq,
  input wire busWrite,
  input wire [7:0] busAddr,
  input wire [7:0] busWrData,
  output reg busBusy,
  output reg busDone,
  output reg [7:0] busRdData,
  // general purpose pins, enable low while driving
  input wire [10:0] gpPinsIn,
  output reg [10:0] gpPinsOut,
  output reg [10:0] gpPinsOe_n
);

  // ***********************************************
  // bus cycle states
  // ***********************************************
  localparam ST_IDLE = 5'h01;
  localparam ST_ADDR = 5'h02;
  localparam ST_GAP = 5'h04;
  localparam ST_STROBE = 5'h08;
  localparam ST_HOLD = 5'h10;

  reg [4:0] state;
  reg [4:0] next_state;
  reg [15:0] phaseCnt;
  reg lastPhase;
  reg cycWrite;
  reg [7:0] cycAddr;
  reg [7:0] cycData;

  // ***********************************************
  // test select
  // ***********************************************
  wire normalMode = (testSelectPin == `TEST_NORMAL);
  wire busMode = normalMode && (extPortModeSel == `MODE_EXT_BUS);

  // test mode flag, gp pins and timer output are parked while it is set
  always @(posedge ref_clk) begin
    if (rst) begin
      testModeActive <= 1'b0;
    end else begin
      testModeActive <= ~normalMode;
    end
  end

  // ***********************************************
  // square wave timer
  // ***********************************************
  reg [31:0] halfMsCnt;
  reg halfMsTick;
  reg [6:0] halfCnt;
  wire [31:0] halfMsLast = HALF_MS_CYCLES - 1;

  // half-millisecond enable pulse from the prescaler
  always @(posedge ref_clk) begin
    if (rst) begin
      halfMsCnt <= 32'h00000000;
      halfMsTick <= 1'b0;
    end else if (halfMsCnt >= halfMsLast) begin
      halfMsCnt <= 32'h00000000;
      halfMsTick <= 1'b1;
    end else begin
      halfMsCnt <= halfMsCnt + 32'h00000001;
      halfMsTick <= 1'b0;
    end
  end

  // each half of the wave lasts timerPeriodMs half-milliseconds
  always @(posedge ref_clk) begin
    if (rst || !normalMode || timerPeriodMs == `TIMER_PERIOD_OFF) begin
      halfCnt <= 7'h00;
      timerSquareOut <= 1'b0; // a period of zero parks the output low
    end else if (halfMsTick) begin
      if (halfCnt >= {1'b0, timerPeriodMs} - 7'h01) begin
        halfCnt <= 7'h00;
        timerSquareOut <= ~timerSquareOut;
      end else begin
        halfCnt <= halfCnt + 7'h01;
      end
    end
  end

  // ***********************************************
  // external interrupt edges
  // ***********************************************
  reg [1:0] irqPrev;
  reg irqArmed;
  wire [1:0] irqNow = {extIrqInOne, extIrqInZero};
  // armed flag keeps the reset value of irqPrev from faking an edge
  wire [1:0] irqEdge = irqArmed ? (irqNow ^ irqPrev) : `IRQ_NONE;
  wire [1:0] next_pending = (irqPending & ~irqClear) | irqEdge; // set wins over clear

  always @(posedge ref_clk) begin
    if (rst) begin
      irqPrev <= `IRQ_NONE;
      irqArmed <= 1'b0;
      irqPending <= `IRQ_NONE;
      irqReqOut <= 1'b0;
      irqReqOe_n <= 1'b1;
    end else begin
      irqPrev <= irqNow;
      irqArmed <= 1'b1;
      irqPending <= next_pending;
      irqReqOut <= 1'b0; // only ever pulls low
      irqReqOe_n <= ~|(next_pending & irqMask);
    end
  end

  // ***********************************************
  // external bus sequencer
  // ***********************************************
  wire [31:0] phaseLastFull = PHASE_CYCLES - 1;
  wire [15:0] phaseLast = phaseLastFull[15:0]; // phase counter is only 16 bits wide

  always @* begin
    lastPhase = (phaseCnt >= phaseLast);
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (busReq && busMode) begin
          // non-muxed addressing skips the latch phase
          next_state = (extAddrModeSel == `ADDR_MUXED) ? ST_ADDR : ST_STROBE;
        end
      end
      ST_ADDR: begin
        if (lastPhase) begin
          next_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (lastPhase) begin
          next_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (lastPhase) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (lastPhase) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state, phase counter and captured request
  always @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      phaseCnt <= 16'h0000;
      cycWrite <= 1'b0;
      cycAddr <= `BYTE_ZERO;
      cycData <= `BYTE_ZERO;
      busBusy <= 1'b0;
      busDone <= 1'b0;
      busRdData <= `BYTE_ZERO;
    end else begin
      state <= next_state;
      busDone <= 1'b0;
      if (next_state != state) begin
        phaseCnt <= 16'h0000;
      end else begin
        phaseCnt <= phaseCnt + 16'h0001;
      end
      if (state == ST_IDLE && next_state != ST_IDLE) begin
        cycWrite <= busWrite;
        cycAddr <= busAddr;
        cycData <= busWrData;
      end
      // read data is taken at the end of the strobe, while the peripheral drives
      if (state == ST_STROBE && lastPhase && !cycWrite) begin
        busRdData <= gpPinsIn[`GP_BUS_MSB:`GP_BUS_LSB];
      end
      if (state == ST_HOLD && lastPhase) begin
        busDone <= 1'b1;
      end
      busBusy <= (next_state != ST_IDLE);
    end
  end

  // ***********************************************
  // pin drivers
  // ***********************************************
  reg [10:0] next_pinOut;
  reg [10:0] next_pinOe_n;

  // a request taken on this edge is not captured yet, so its fields come straight
  // from the inputs; otherwise the first phase would show the previous cycle's values
  wire taking = (state == ST_IDLE) && (next_state != ST_IDLE);
  wire useWrite = taking ? busWrite : cycWrite;
  wire [7:0] useAddr = taking ? busAddr : cycAddr;
  wire [7:0] useData = taking ? busWrData : cycData;

  always @* begin
    next_pinOut = `GP_ALL_ZERO;
    next_pinOe_n = `GP_ALL_RELEASED;
    if (!normalMode) begin
      // test mode keeps everything released
      next_pinOe_n = `GP_ALL_RELEASED;
    end else if (busMode) begin
      // strobes are always driven in bus mode, idle levels between cycles
      next_pinOe_n[`GP_LATCH_PIN] = 1'b0;
      next_pinOe_n[`GP_READ_PIN] = 1'b0;
      next_pinOe_n[`GP_WRITE_PIN] = 1'b0;
      next_pinOut[`GP_LATCH_PIN] = (next_state == ST_ADDR);
      next_pinOut[`GP_READ_PIN] = ~(next_state == ST_STROBE && !useWrite);
      next_pinOut[`GP_WRITE_PIN] = ~(next_state == ST_STROBE && useWrite);
      if (next_state == ST_ADDR) begin
        next_pinOut[`GP_BUS_MSB:`GP_BUS_LSB] = useAddr;
        next_pinOe_n[`GP_BUS_MSB:`GP_BUS_LSB] = `BYTE_ZERO;
      end else if (useWrite && (next_state == ST_STROBE || next_state == ST_HOLD)) begin
        next_pinOut[`GP_BUS_MSB:`GP_BUS_LSB] = useData;
        next_pinOe_n[`GP_BUS_MSB:`GP_BUS_LSB] = `BYTE_ZERO;
      end
    end else begin
      next_pinOut = pinWriteData;
      next_pinOe_n = ~pinDirection;
    end
  end

  // registered pins, so every pin changes only on the clock edge
  always @(posedge ref_clk) begin
    if (rst) begin
      gpPinsOut <= `GP_ALL_ZERO;
      gpPinsOe_n <= `GP_ALL_RELEASED;
      pinReadData <= `GP_ALL_ZERO;
    end else begin
      gpPinsOut <= next_pinOut;
      gpPinsOe_n <= next_pinOe_n;
      pinReadData <= gpPinsIn;
    end
  end

endmodule

// *** logic/periph_ctrl_defs.vh ***
// constants shared by the peripheral control port
`ifndef PERIPH_CTRL_DEFS_VH
`define PERIPH_CTRL_DEFS_VH

// pin map of the eleven general purpose pins
`define GP_PIN_COUNT 11
`define GP_BUS_LSB 0
`define GP_BUS_MSB 7
`define GP_LATCH_PIN 8
`define GP_READ_PIN 9
`define GP_WRITE_PIN 10

// reset values
`define GP_ALL_RELEASED 11'h7ff
`define GP_ALL_ZERO 11'h000
`define BYTE_ZERO 8'h00
`define IRQ_NONE 2'h0

// mode select encodings
`define MODE_SIMPLE_IO 1'b0
`define MODE_EXT_BUS 1'b1
`define ADDR_MUXED 1'b1
`define TEST_NORMAL 1'b1

// timer: half a millisecond per tick, period in whole milliseconds
`define TIMER_HALF_MS_NS 500000
`define CLK_PERIOD_NS 5
`define TIMER_PERIOD_OFF 6'h00
`define TIMER_PERIOD_WIDTH 6

// external bus phase length in ref_clk cycles
`define BUS_PHASE_CYCLES 4

`endif

// *** verification/pcp_asserts.sv ***
// checker bound to the peripheral control port
`timescale 1ns/1ps
module pcp_checker #(parameter HALF_MS_CYCLES = 10, parameter PHASE_CYCLES = 2) (
  // watched ports
  input wire ref_clk,
  input wire rst,
  input wire extPortModeSel,
  input wire extAddrModeSel,
  input wire testSelectPin,
  input wire [10:0] pinDirection,
  input wire extIrqInZero,
  input wire [1:0] irqMask,
  input wire [1:0] irqPending,
  input wire irqReqOe_n,
  input wire busBusy,
  input wire busDone,
  input wire [10:0] gpPinsOe_n
);
  localparam int MUX_WAIT = 4 * PHASE_CYCLES;
  // mode qualifiers, test select low overrides both
  wire ioMode = !extPortModeSel && testSelectPin;
  wire busMode = extPortModeSel && testSelectPin;
  // one clock, the sync reset disables every check except a_pins_free
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pins_free: assert property (disable iff (1'b0) rst |=> gpPinsOe_n == 11'h7ff)
    else $error("pins driven after reset");
  a_irq_edge: assert property (!$past(rst) && $changed(extIrqInZero) |=> irqPending[0])
    else $error("edge not flagged");
  a_line_low: assert property ($stable(irqMask) |-> irqReqOe_n != |(irqPending & irqMask))
    else $error("request line wrong");
  a_io_dir: assert property (ioMode |=> gpPinsOe_n == ~$past(pinDirection))
    else $error("pin direction wrong");
  a_test_off: assert property (!testSelectPin |=> gpPinsOe_n == 11'h7ff)
    else $error("pins kept in test");
  a_bus_pins: assert property (busMode |=> gpPinsOe_n[10:8] == 3'h0)
    else $error("strobes not driven");
  a_mux_time: assert property ($rose(busBusy) && extAddrModeSel |-> ##MUX_WAIT busDone)
    else $error("bus cycle length wrong");
  a_done_once: assert property (busDone |-> !busBusy ##1 !busDone)
    else $error("done not a pulse");
  // main scenarios
  c_bus: cover property ($rose(busBusy));
  c_irq: cover property (!irqReqOe_n);
  c_test: cover property (!testSelectPin);
endmodule

bind peripheral_control_port pcp_checker #(.HALF_MS_CYCLES(HALF_MS_CYCLES),
  .PHASE_CYCLES(PHASE_CYCLES)) chk (.ref_clk, .rst, .extPortModeSel, .extAddrModeSel,
  .testSelectPin, .pinDirection, .extIrqInZero, .irqMask, .irqPending, .irqReqOe_n,
  .busBusy, .busDone, .gpPinsOe_n);

// *** verification/periph_model.sv ***
// far side model: peripheral chips on the gp pins
`timescale 1ns/1ps
module periph_model (
  // pins and the byte a read returns
  input wire [10:0] pinsOut,
  input wire [10:0] pinsOe_n,
  input wire [7:0] rdByte,
  output wire [10:0] pinsIn
);
  // released lines show the inverse so stale data never matches
  wire rdLow = !pinsOe_n[9] && !pinsOut[9];
  wire [10:0] far = rdLow ? {~pinsOut[10:8], rdByte} : ~pinsOut;
  assign pinsIn = (~pinsOe_n & pinsOut) | (pinsOe_n & far);
endmodule

// *** verification/peripheral_control_port_tb_top.sv ***
// bench for the peripheral control port
`timescale 1ns/1ps
module peripheral_control_port_tb_top;
  reg ref_clk = 1'h0, rst = 1'h1, ext_port_mode_sel = 1'h0, ext_addr_mode_sel = 1'h0, tSel = 1'h1;
  reg irq0 = 1'h0, irq1 = 1'h0, req = 1'h0, wr = 1'h0;
  reg [10:0] dir = 11'h000, wd = 11'h000;
  reg [5:0] per = 6'h00;
  reg [1:0] mask = 2'h1, clr = 2'h0;
  reg [7:0] adr = 8'h00, wdat = 8'h00, rdB = 8'h00, lastRd = 8'h00;
  reg [7:0] expQ [$];
  wire tAct, sq, oe_n, busy, done, reqLvl;
  wire [1:0] pend;
  wire [7:0] rd;
  wire [10:0] pinRd, pIn, pOut, pOe_n;
  integer num_errors = 0, n_tests = 0, seed = 63610, i, k;
  // 200 MHz
  initial forever #2.5 ref_clk = ~ref_clk;
  peripheral_control_port #(.HALF_MS_CYCLES(10), .PHASE_CYCLES(2)) DUT (.ref_clk, .rst,
    .extPortModeSel(ext_port_mode_sel), .extAddrModeSel(ext_addr_mode_sel), .testSelectPin(tSel),
    .testModeActive(tAct), .pinDirection(dir), .pinWriteData(wd), .pinReadData(pinRd),
    .timerPeriodMs(per), .timerSquareOut(sq), .extIrqInZero(irq0), .extIrqInOne(irq1),
    .irqMask(mask), .irqClear(clr), .irqPending(pend), .irqReqOut(reqLvl), .irqReqOe_n(oe_n),
    .busReq(req), .busWrite(wr), .busAddr(adr), .busWrData(wdat), .busBusy(busy),
    .busDone(done), .busRdData(rd), .gpPinsIn(pIn), .gpPinsOut(pOut), .gpPinsOe_n(pOe_n));
  periph_model far (.pinsOut(pOut), .pinsOe_n(pOe_n), .rdByte(rdB), .pinsIn(pIn));
  task cmp(input string what, input [10:0] exp, input [10:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_of_test;
    $display("%0d checks, %0d wrong", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one bus cycle; a write leaves the last read byte standing
  task bus(input w);
    wr = w;
    adr = $random(seed);
    wdat = $random(seed);
    rdB = $random(seed);
    if (!w) lastRd = rdB;
    expQ.push_back(lastRd);
    req = 1'h1;
    @(negedge ref_clk) req = 1'h0;
    cmp("busy", 1'h1, busy);
    if (ext_addr_mode_sel) cmp("address", {1'h1, adr}, pOut[8:0]);
    for (k = 0; k < 40 && done !== 1'h1; k = k + 1) begin
      if (w && pOut[10] === 1'h0) cmp("wdata", wdat, pOut[7:0]);
      @(negedge ref_clk);
    end
    if (k == 40) num_errors = num_errors + 1;
  endtask
  // watcher takes the oldest note at each done pulse
  always @(negedge ref_clk) if (done === 1'h1) cmp("rdata", expQ.pop_front(), rd);
  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'h0;
    @(negedge ref_clk);
    cmp("released", 11'h7ff, pOe_n);
    cmp("line idle", 1'h1, oe_n);
    $display("reset test ended");
    for (i = 0; i < 6; i = i + 1) begin
      dir = $random(seed);
      wd = $random(seed);
      repeat (2) @(negedge ref_clk);
      cmp("drivers", ~dir, pOe_n);
      cmp("readback", wd & dir, pinRd & dir);
    end
    $display("simple io test ended");
    // both edge directions, bit one stays masked
    for (i = 0; i < 2; i = i + 1) begin
      irq0 = ~irq0;
      irq1 = ~irq1;
      @(negedge ref_clk) clr = 2'h1;
      cmp("pending", 2'h3, pend);
      cmp("line", 1'h0, oe_n);
      cmp("line level", 1'h0, reqLvl);
      @(negedge ref_clk) clr = 2'h2;
      cmp("masked", 1'h1, oe_n);
      @(negedge ref_clk) clr = 2'h0;
      cmp("cleared", 2'h0, pend);
    end
    $display("irq test ended");
    tSel = 1'h0;
    dir = 11'h7ff;
    @(negedge ref_clk);
    cmp("test mode", 1'h1, tAct);
    cmp("test pins", 11'h7ff, pOe_n);
    tSel = 1'h1;
    ext_port_mode_sel = 1'h1;
    // back to back, plain and muxed addressing
    for (i = 0; i < 4; i = i + 1) begin
      ext_addr_mode_sel = i[1];
      bus(i[0]);
    end
    $display("bus test ended");
    for (i = 0; i < 2; i = i + 1) begin
      per = i ? 6'h3f : 6'h01;
      repeat (2) @(posedge sq);
      // first negedge of the high half, then one count per further negedge
      @(negedge ref_clk);
      for (k = 0; sq === 1'h1; k = k + 1) @(negedge ref_clk);
      cmp("half period", 10 * per, k);
    end
    $display("timer test ended");
    end_of_test;
  end
  initial begin
    #100000 num_errors = num_errors + 1;
    end_of_test;
  end
endmodule
